/* design/lccr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - chan_a_current_low at 04h, reset zero
// - chan_b_current_high at 05h, bits 1:0 code
// - chan_b_current_low at 06h, reset zero
// - chan_c_current_high at 07h, bits 1:0 code
// - chan_c_current_low at 08h, reset zero
// - chan_a_current_high at 03h, bits 1:0 code
module lccr_regs
	import lccr_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// current codes to the regulator
	output logic [9:0] chan_a_current_code,
	output logic [9:0] chan_b_current_code,
	output logic [9:0] chan_c_current_code
);
	// ****************************************
	// address decode
	// ****************************************
	localparam int IW = $clog2(LCCR_NUM_REGS);
	// word index from the byte address
	wire [5:0] word_idx = paddr[7:2];
	wire [5:0] first_idx = {2'b00, LCCR_IDX_FIRST};
	wire [5:0] rel_idx = word_idx - first_idx;
	// hit only on aligned words inside the bank
	wire hit = (paddr[1:0] == 2'b00) && (word_idx >= first_idx)
		&& (rel_idx < 6'(LCCR_NUM_REGS));
	wire [IW-1:0] bank_idx = rel_idx[IW-1:0];
	// setup phase: the read is launched one cycle early
	wire setup = psel && !penable;
	// writes take effect in the access phase; lane 0 only carries data
	wire do_write = psel && penable && pwrite && hit && pstrb[0];
	wire [LCCR_REG_W-1:0] rf_rd;
	wire [LCCR_NUM_REGS*LCCR_REG_W-1:0] rf_words;

	// ****************************************
	// storage
	// ****************************************
	lccr_regfile #(
		.DEPTH(LCCR_NUM_REGS),
		.WIDTH(LCCR_REG_W)
	) u_rf (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.wr_en(do_write),
		.wr_idx(bank_idx),
		.wr_data(pwdata[LCCR_REG_W-1:0]),
		.rd_idx(bank_idx),
		.rd_data(rf_rd),
		.words(rf_words)
	);

	// ****************************************
	// bus answer
	// ****************************************
	// byte of the addressed word, picked from the flat register outputs;
	// a miss gives zero so no out-of-range select reaches the bus
	wire [LCCR_REG_W-1:0] sel_byte = hit ? rf_words[bank_idx*LCCR_REG_W +: LCCR_REG_W]
		: LCCR_RESET_VAL;
	// hit state of the setup cycle, kept for the read path check
	logic hit_q;
	// pready rises in the first access cycle: one wait-free access phase
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			hit_q <= 1'b0;
		else if (setup)
			hit_q <= hit;
	end
	// ready and error registered in the setup cycle
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !hit;
		end
	end
	// read data registered in the setup cycle, so it stands with pready for one
	// cycle and comes from a flop; the registered array read loads at the same edge and is used to check it
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			prdata <= LCCR_ZERO_WORD;
		else if (setup && hit)
			prdata <= {24'h00_0000, sel_byte};
		else
			prdata <= LCCR_ZERO_WORD;
	end

	// ****************************************
	// code outputs
	// ****************************************
	// upper register bits 1:0 over lower byte; follows any write at once
	generate
		for (genvar c = 0; c < LCCR_NUM_CHAN; c++)
		begin : g_code
			logic [LCCR_CODE_W-1:0] code;
			assign code = {rf_words[(2*c)*LCCR_REG_W +: LCCR_HIGH_W],
				rf_words[(2*c+1)*LCCR_REG_W +: LCCR_REG_W]};
		end
	endgenerate
	// codes registered so the outputs come from flip-flops
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			chan_a_current_code <= '0;
			chan_b_current_code <= '0;
			chan_c_current_code <= '0;
		end
		else
		begin
			chan_a_current_code <= g_code[0].code;
			chan_b_current_code <= g_code[1].code;
			chan_c_current_code <= g_code[2].code;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	// software limit: not enforced, codes above 307h pass unchanged
	// byte addresses below are the word index shifted up by two

	// an accepted write to one byte address, as the slave takes it
	sequence s_write_at(logic [7:0] addr);
		psel && penable && pwrite && pstrb[0] && (paddr == addr);
	endsequence

	// the same access with lane 0 off, which must store nothing
	sequence s_dropped_at(logic [7:0] addr);
		psel && penable && pwrite && !pstrb[0] && (paddr == addr);
	endsequence

	// the register takes the byte at the access edge, the code flop one edge later
	code_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_write_at({2'b00, LCCR_IDX_A_LOW, 2'b00})
		|-> ##2 (chan_a_current_code[7:0] == $past(pwdata[7:0], 2)))
		else $error("channel a low byte not applied");

	// channel b low byte follows its write the same way
	low_b_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_write_at({2'b00, LCCR_IDX_B_LOW, 2'b00})
		|-> ##2 (chan_b_current_code[7:0] == $past(pwdata[7:0], 2)))
		else $error("channel b low byte not applied");

	// channel c low byte
	low_c_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_write_at({2'b00, LCCR_IDX_C_LOW, 2'b00})
		|-> ##2 (chan_c_current_code[7:0] == $past(pwdata[7:0], 2)))
		else $error("channel c low byte not applied");

	// only bits 1:0 of a high register reach the code
	high_a_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_write_at({2'b00, LCCR_IDX_A_HIGH, 2'b00})
		|-> ##2 (chan_a_current_code[9:8] == $past(pwdata[1:0], 2)))
		else $error("channel a high bits not applied");

	// channel b high bits
	high_b_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_write_at({2'b00, LCCR_IDX_B_HIGH, 2'b00})
		|-> ##2 (chan_b_current_code[9:8] == $past(pwdata[1:0], 2)))
		else $error("channel b high bits not applied");

	// channel c high bits
	high_c_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_write_at({2'b00, LCCR_IDX_C_HIGH, 2'b00})
		|-> ##2 (chan_c_current_code[9:8] == $past(pwdata[1:0], 2)))
		else $error("channel c high bits not applied");

	// a write without lane 0 leaves the code where it was
	strobe_drop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_dropped_at({2'b00, LCCR_IDX_A_LOW, 2'b00}) |-> ##2 $stable(chan_a_current_code))
		else $error("write without lane 0 changed a code");

	// the three codes, pready and pslverr are quiet at the first edge after reset is released
	reset_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(rstn) |-> ((chan_a_current_code == 10'h000) && (chan_b_current_code == 10'h000)
			&& (chan_c_current_code == 10'h000) && !pready && !pslverr))
		else $error("code not zero after reset");

	// no wait states: the answer comes in the first access cycle
	ready_one_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(psel && !penable) |=> pready)
		else $error("pready not given after setup");

	// an error is only ever reported together with pready
	err_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		pslverr |-> pready)
		else $error("pslverr without pready");

	// unaligned or outside the bank: refused, and the read gives zero
	miss_err_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(psel && !penable && ((paddr[1:0] != 2'b00) || (paddr[7:2] < {2'b00, LCCR_IDX_FIRST})
			|| (paddr[7:2] > {2'b00, LCCR_IDX_C_LOW})))
		|=> (pslverr && (prdata == LCCR_ZERO_WORD)))
		else $error("unmapped access not refused");

	// the fast read path and the registered array read must agree
	read_agree_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(pready && hit_q) |-> (prdata == {24'h00_0000, rf_rd}))
		else $error("read data differs from the stored byte");

	// outside an answer the read bus stays at zero
	idle_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!pready |-> (prdata == LCCR_ZERO_WORD))
		else $error("read data shown outside an answer");
endmodule // lccr_regs
`default_nettype wire

/* common/lccr_pkg.sv */
package lccr_pkg;
	// ****************************************
	// register indices (printed offsets)
	// ****************************************
	localparam logic [3:0] LCCR_IDX_A_HIGH = 4'h3; // chan_a_current_high
	localparam logic [3:0] LCCR_IDX_A_LOW = 4'h4; // chan_a_current_low
	localparam logic [3:0] LCCR_IDX_B_HIGH = 4'h5; // chan_b_current_high
	localparam logic [3:0] LCCR_IDX_B_LOW = 4'h6; // chan_b_current_low
	localparam logic [3:0] LCCR_IDX_C_HIGH = 4'h7; // chan_c_current_high
	localparam logic [3:0] LCCR_IDX_C_LOW = 4'h8; // chan_c_current_low
	// first index and count of the bank
	localparam logic [3:0] LCCR_IDX_FIRST = 4'h3;
	localparam int LCCR_NUM_REGS = 6;
	// ****************************************
	// field layout and reset values
	// ****************************************
	localparam int LCCR_REG_W = 8; // register width
	localparam int LCCR_CODE_W = 10; // combined current code width
	localparam int LCCR_HIGH_W = 2; // code bits held in a high register
	localparam int LCCR_NUM_CHAN = 3;
	localparam logic [7:0] LCCR_RESET_VAL = 8'h00;
	localparam logic [9:0] LCCR_CODE_MAX = 10'h307; // highest usable code
	localparam logic [31:0] LCCR_ZERO_WORD = 32'h0000_0000;
endpackage

/* design/lccr_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// small register array, registered read
// ****************************************
module lccr_regfile
	import lccr_pkg::*;
#(
	parameter int DEPTH = LCCR_NUM_REGS,
	parameter int WIDTH = LCCR_REG_W
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// write port
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data,
	// all words flat, for the code outputs
	output logic [DEPTH*WIDTH-1:0] words
);
	// index width shared by both ports
	localparam int AW = $clog2(DEPTH);

	// ****************************************
	// parameter guard
	// ****************************************
	// a single word would leave a zero-width index
	generate
		if (DEPTH < 2 || WIDTH < 1)
		begin : g_bad_param
			$error("lccr_regfile needs DEPTH of at least 2 and WIDTH of at least 1");
		end
	endgenerate

	// ****************************************
	// storage
	// ****************************************
	generate
		for (genvar i = 0; i < DEPTH; i++)
		begin : g_word
			// one register per entry, each with its own driver
			logic [WIDTH-1:0] word;
			// reset to zero so every code starts at no drive
			always_ff @(posedge sys_clk or negedge rstn)
			begin
				if (!rstn)
					word <= '0;
				else if (wr_en && (wr_idx == AW'(i)))
					word <= wr_data;
			end
			assign words[i*WIDTH +: WIDTH] = word;
		end
	endgenerate

	// indices past the last entry read as zero rather than unknown
	wire [WIDTH-1:0] rd_word = (int'(rd_idx) < DEPTH) ? words[rd_idx*WIDTH +: WIDTH] : '0;

	// read data leaves from a register
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			rd_data <= '0;
		else
			rd_data <= rd_word;
	end
endmodule // lccr_regfile
`default_nettype wire

/* testbench/lccr_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench for the current code registers
// ****************************************
module testbench
	import lccr_pkg::*;
;
	// clock, reset and apb master
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, rnd_addr;
	logic [31:0] pwdata, prdata, rd, d, r;
	logic [3:0] pstrb;
	// codes seen at the regulator side
	logic [9:0] code_a, code_b, code_c;
	// model of the six bytes, index minus first index
	logic [7:0] m [6];
	int bad_count, checked, i;
	int seed = 11;

	lccr_regs i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chan_a_current_code(code_a),
		.chan_b_current_code(code_b), .chan_c_current_code(code_c));

	// free running 25 MHz clock
	initial
	begin
		sys_clk = 0;
		forever #20 sys_clk = ~sys_clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, then the codes are compared after they settle
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s);
		int n;
		int k;
		logic hit;
		k = int'(a[7:2]) - int'(LCCR_IDX_FIRST);
		hit = (a[1:0] == 2'b00) && k >= 0 && k < LCCR_NUM_REGS;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		// no wait count assumed: bounded poll of pready
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		// a slave that never answers counts as a mismatch here
		chk(32'(pready), 32'h0000_0001);
		rd = prdata;
		err = pslverr;
		if (!w)
			chk(rd, hit ? 32'(m[k]) : LCCR_ZERO_WORD);
		chk(32'(err), 32'(!hit));
		// a dropped strobe or a miss leaves the model alone
		if (w && hit && s[0])
			m[k] = dat[7:0];
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk(32'(code_a), 32'({m[0][1:0], m[1]}));
		chk(32'(code_b), 32'({m[2][1:0], m[3]}));
		chk(32'(code_c), 32'({m[4][1:0], m[5]}));
		@(posedge sys_clk);
	endtask

	// all six registers read back against the model
	task readall;
		for (int j = 0; j < LCCR_NUM_REGS; j++)
			xfer(0, 8'((j + 3) * 4), 32'h0000_0000, 4'hF);
	endtask

	task stop_test;
		if (bad_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		rstn = 0;
		for (i = 0; i < 6; i++)
			m[i] = 8'h00;
		repeat (20) @(posedge sys_clk);
		rstn <= 1;
		@(posedge sys_clk);
		readall();
		// upper bits of a high register kept, code unchanged
		xfer(1, 8'h0C, 32'h0000_00FC, 4'h1);
		xfer(0, 8'h11, 32'h0000_0000, 4'hF);
		for (i = 0; i < 150; i++)
		begin
			r = $random(seed);
			d = $random(seed);
			// software keeps codes at or below the top code
			if (d[1:0] == 2'b11)
				d[1:0] = 2'b10;
			// word indices 0 to 11 reach both ends of the bank and the misses around it
			rnd_addr = {6'(r[3:0] % 12), (r[12] && r[13]) ? r[10:9] : 2'b00};
			xfer(r[8], rnd_addr, d, r[7:4]);
		end
		// top usable code on every channel, low byte first
		for (i = 0; i < 3; i++)
		begin
			xfer(1, 8'(16 + 8 * i), 32'(LCCR_CODE_MAX[7:0]), 4'hF);
			xfer(1, 8'(12 + 8 * i), 32'(LCCR_CODE_MAX[9:8]), 4'hF);
		end
		readall();
		// second reset in mid run clears every byte
		rstn <= 0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1;
		for (i = 0; i < 6; i++)
			m[i] = 8'h00;
		@(posedge sys_clk);
		readall();
		stop_test();
	end

	// hang guard, far beyond the expected run
	initial
	begin
		#800000;
		bad_count++;
		stop_test();
	end
endmodule // testbench
`default_nettype wire
